// ### hw/sbg_top.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`include "sbg_params.svh"

// Notes on behaviour
// - Setting then clearing the break request sends exactly one break.
// - With eight-bit words outside LIN master mode a break lasts exactly 10 bit times.
// - With nine-bit words a break lasts exactly 11 bit times.
// - Breaks repeat back to back while requested; none extra after clearing.
// - LIN master mode when LIN enable is set and word length is clear.
// - In LIN master mode a break lasts exactly 13 bit times.
// - Clearing then setting transmitter enable sends one idle character first.
// - An idle before a LIN break is 10 bit times of high line.
module sbg_top (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line.
  output logic             tx_line
);

  // ========================================================================
  // Registers.
  logic        word_len_q;
  logic        send_break_request_q;
  logic        tx_on_q;
  logic        lin_en_q;
  logic [15:0] baud_q;
  logic        idle_pend_q;
  logic        break_seen_q;
  logic        lin_mode;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;

  sbg_pkg::sbg_state_e state_q;
  logic [4:0]  bits_q;
  logic [10:0] shift_q;
  logic        tick;
  logic        restart;
  logic        char_end;
  logic        break_start;

  logic        f_in_valid;
  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [8:0]  f_out_data;
  logic        f_full;
  logic        f_empty;

  assign lin_mode = lin_en_q && !word_len_q;
  assign wr_en    = psel && penable && pwrite && pready;
  assign rd_en    = psel && !penable && !pwrite;
  assign addr_ok  = paddr == `SBG_ADDR_CTRL_ONE ||
                    paddr == `SBG_ADDR_CTRL_TWO ||
                    paddr == `SBG_ADDR_CTRL_THREE ||
                    paddr == `SBG_ADDR_BAUD ||
                    paddr == `SBG_ADDR_DATA ||
                    paddr == `SBG_ADDR_STATUS;
  // A data write is taken only when the FIFO has room.
  assign f_in_valid = wr_en && paddr == `SBG_ADDR_DATA;

  // ========================================================================
  // APB handshake: one wait state; data writes wait for FIFO room.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && pready) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable) begin
      pready  <= !(pwrite && paddr == `SBG_ADDR_DATA) || f_in_ready;
      pslverr <= !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `SBG_ADDR_CTRL_ONE: begin
          prdata[`SBG_BIT_WORD_LEN] <= word_len_q;
        end
        `SBG_ADDR_CTRL_TWO: begin
          prdata[`SBG_BIT_SEND_BREAK] <= send_break_request_q;
          prdata[`SBG_BIT_TX_ON]      <= tx_on_q;
        end
        `SBG_ADDR_CTRL_THREE: begin
          prdata[`SBG_BIT_LIN_EN] <= lin_en_q;
        end
        `SBG_ADDR_BAUD: begin
          prdata[15:0] <= baud_q;
        end
        `SBG_ADDR_STATUS: begin
          prdata[`SBG_BIT_ST_BUSY]  <= state_q != sbg_pkg::SBG_IDLE;
          prdata[`SBG_BIT_ST_FULL]  <= f_full;
          prdata[`SBG_BIT_ST_EMPTY] <= f_empty;
          prdata[`SBG_BIT_ST_LIN]   <= lin_mode;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ========================================================================
  // Control register writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_len_q           <= 1'b0;
      send_break_request_q <= 1'b0;
      tx_on_q              <= 1'b0;
      lin_en_q             <= 1'b0;
      baud_q               <= `SBG_BAUD_RESET;
    end else if (wr_en) begin
      case (paddr)
        `SBG_ADDR_CTRL_ONE: begin
          word_len_q <= pwdata[`SBG_BIT_WORD_LEN];
        end
        `SBG_ADDR_CTRL_TWO: begin
          send_break_request_q <= pwdata[`SBG_BIT_SEND_BREAK];
          tx_on_q              <= pwdata[`SBG_BIT_TX_ON];
        end
        `SBG_ADDR_CTRL_THREE: begin
          lin_en_q <= pwdata[`SBG_BIT_LIN_EN];
        end
        `SBG_ADDR_BAUD: begin
          baud_q <= pwdata[15:0];
        end
        default: begin
          baud_q <= baud_q;
        end
      endcase
    end
  end

  // ========================================================================
  // Request latches. A rising transmitter enable queues one idle, a set
  // break request queues one break even if cleared before a boundary.
  // The queued break is consumed as it starts, so a request cleared during
  // the stop bit cannot leave a stale break behind.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_pend_q <= 1'b0;
    end else if (wr_en && paddr == `SBG_ADDR_CTRL_TWO &&
                 pwdata[`SBG_BIT_TX_ON] && !tx_on_q) begin
      idle_pend_q <= 1'b1;
    end else if (char_end && state_q == sbg_pkg::SBG_PRE) begin
      idle_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_seen_q <= 1'b0;
    end else if (wr_en && paddr == `SBG_ADDR_CTRL_TWO &&
                 pwdata[`SBG_BIT_SEND_BREAK]) begin
      break_seen_q <= 1'b1;
    end else if (break_start) begin
      break_seen_q <= 1'b0;
    end
  end

  // ========================================================================
  // Transmitter sequencer.
  assign restart     = !tx_on_q;
  assign char_end    = tick && bits_q == 5'd1;
  // A queued break starts at a boundary: from idle, or straight after an
  // idle character so that no extra gap stretches the header.
  assign break_start = tx_on_q && tick && break_seen_q &&
                       ((state_q == sbg_pkg::SBG_IDLE && !idle_pend_q) ||
                        (state_q == sbg_pkg::SBG_PRE && bits_q == 5'd1));
  assign f_out_ready = tx_on_q && state_q == sbg_pkg::SBG_IDLE && tick &&
                       !idle_pend_q && !break_seen_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sbg_pkg::SBG_IDLE;
      bits_q  <= 5'd0;
      shift_q <= 11'h7ff;
      tx_line <= 1'b1;
    end else if (!tx_on_q) begin
      state_q <= sbg_pkg::SBG_IDLE;
      bits_q  <= 5'd0;
      tx_line <= 1'b1;
    end else if (tick) begin
      case (state_q)
        sbg_pkg::SBG_IDLE: begin
          // Requests are picked up only at a character boundary.
          if (idle_pend_q) begin
            state_q <= sbg_pkg::SBG_PRE;
            bits_q  <= lin_mode ? `SBG_IDLE_BITS_8
                     : (word_len_q ? `SBG_IDLE_BITS_9 : `SBG_IDLE_BITS_8);
            tx_line <= 1'b1;
          end else if (break_seen_q) begin
            state_q <= sbg_pkg::SBG_BREAK;
            bits_q  <= lin_mode ? `SBG_BREAK_BITS_LIN
                     : (word_len_q ? `SBG_BREAK_BITS_9
                                   : `SBG_BREAK_BITS_8);
            tx_line <= 1'b0;
          end else if (f_out_valid) begin
            state_q <= sbg_pkg::SBG_DATA;
            bits_q  <= word_len_q ? `SBG_DATA_BITS_9 : `SBG_DATA_BITS_8;
            shift_q <= word_len_q ? {1'b1, f_out_data, 1'b0}
                                  : {2'b11, f_out_data[7:0], 1'b0};
            tx_line <= 1'b0;
          end else begin
            tx_line <= 1'b1;
          end
        end
        sbg_pkg::SBG_PRE: begin
          if (bits_q == 5'd1 && break_seen_q) begin
            // The break follows the idle at once, keeping the idle exact.
            state_q <= sbg_pkg::SBG_BREAK;
            bits_q  <= lin_mode ? `SBG_BREAK_BITS_LIN
                     : (word_len_q ? `SBG_BREAK_BITS_9 : `SBG_BREAK_BITS_8);
            tx_line <= 1'b0;
          end else begin
            bits_q <= bits_q - 5'd1;
            if (bits_q == 5'd1) begin
              state_q <= sbg_pkg::SBG_IDLE;
            end
          end
        end
        sbg_pkg::SBG_BREAK: begin
          bits_q <= bits_q - 5'd1;
          if (bits_q == 5'd1) begin
            state_q <= sbg_pkg::SBG_STOP;
            tx_line <= 1'b1;
          end else begin
            tx_line <= 1'b0;
          end
        end
        sbg_pkg::SBG_DATA: begin
          bits_q  <= bits_q - 5'd1;
          shift_q <= {1'b1, shift_q[10:1]};
          tx_line <= shift_q[1];
          if (bits_q == 5'd1) begin
            state_q <= sbg_pkg::SBG_IDLE;
            tx_line <= 1'b1;
          end
        end
        sbg_pkg::SBG_STOP: begin
          // One stop bit, then back to back breaks while requested.
          if (send_break_request_q) begin
            state_q <= sbg_pkg::SBG_BREAK;
            bits_q  <= lin_mode ? `SBG_BREAK_BITS_LIN
                     : (word_len_q ? `SBG_BREAK_BITS_9 : `SBG_BREAK_BITS_8);
            tx_line <= 1'b0;
          end else begin
            state_q <= sbg_pkg::SBG_IDLE;
            tx_line <= 1'b1;
          end
        end
        default: begin
          state_q <= sbg_pkg::SBG_IDLE;
          tx_line <= 1'b1;
        end
      endcase
    end
  end

  // ========================================================================
  // Submodules.
  sbg_baud u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (restart),
    .divider (baud_q),
    .tick    (tick)
  );

  sbg_fifo #(
    .WIDTH (`SBG_FIFO_WIDTH),
    .DEPTH (`SBG_FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (pwdata[8:0]),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .full      (f_full),
    .empty     (f_empty)
  );

endmodule

// ### hw/sbg_params.svh
`ifndef SBG_PARAMS_SVH
`define SBG_PARAMS_SVH

// ==========================================================================
// Register byte addresses.
`define SBG_ADDR_CTRL_ONE   12'h000
`define SBG_ADDR_CTRL_TWO   12'h004
`define SBG_ADDR_CTRL_THREE 12'h008
`define SBG_ADDR_BAUD       12'h00c
`define SBG_ADDR_DATA       12'h010
`define SBG_ADDR_STATUS     12'h014

// ==========================================================================
// Field positions.
`define SBG_BIT_WORD_LEN    0
`define SBG_BIT_SEND_BREAK  0
`define SBG_BIT_TX_ON       1
`define SBG_BIT_LIN_EN      0
`define SBG_BIT_ST_BUSY     0
`define SBG_BIT_ST_FULL     1
`define SBG_BIT_ST_EMPTY    2
`define SBG_BIT_ST_LIN      3

// ==========================================================================
// Reset values, character lengths in bit times and FIFO size.
`define SBG_BAUD_RESET      16'h0364
`define SBG_BREAK_BITS_8    5'd10
`define SBG_BREAK_BITS_9    5'd11
`define SBG_BREAK_BITS_LIN  5'd13
`define SBG_IDLE_BITS_8     5'd10
`define SBG_IDLE_BITS_9     5'd11
`define SBG_DATA_BITS_8     5'd10
`define SBG_DATA_BITS_9     5'd11
`define SBG_FIFO_DEPTH      8
`define SBG_FIFO_WIDTH      9

`endif

// ### hw/sbg_pkg.sv
package sbg_pkg;

  // ========================================================================
  // Transmitter states, one-hot.
  typedef enum logic [4:0] {
    SBG_IDLE  = 5'b00001,
    SBG_PRE   = 5'b00010,
    SBG_BREAK = 5'b00100,
    SBG_DATA  = 5'b01000,
    SBG_STOP  = 5'b10000
  } sbg_state_e;

endpackage

// ### hw/sbg_fifo.sv
`timescale 1ns/1ns

module sbg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Write side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Read side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // Level.
  output logic                  full,
  output logic                  empty
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign full      = (count_q == (AW+1)'(DEPTH));
  assign empty     = (count_q == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end

endmodule

// ### hw/sbg_baud.sv
`timescale 1ns/1ns

module sbg_baud (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control.
  input  wire logic        restart,
  input  wire logic [15:0] divider,
  // Bit-time tick.
  output logic             tick
);

  logic [15:0] cnt_q;

  // A divider of zero or one gives a tick every clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (restart || cnt_q >= divider) begin
      cnt_q <= 16'h0001;
      tick  <= !restart && (divider <= 16'h0001 || cnt_q >= divider);
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule

// ### sim/sbg_line_rx.sv
`timescale 1ns/1ns

// ==========================================================
// Remote receiver: measures each low and high run on the line.
module sbg_line_rx (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Serial line.
  input  wire logic        tx_line,
  // Measured run lengths in clock cycles, and the count of low runs.
  output logic      [15:0] lo_len,
  output logic      [15:0] hi_len,
  output logic      [15:0] runs
);
  logic [15:0] cnt_q;
  logic        prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0;
      prev_q <= 1'b1;
      lo_len <= 16'h0;
      hi_len <= 16'h0;
      runs   <= 16'h0;
    end else begin
      prev_q <= tx_line;
      if (tx_line != prev_q) begin
        cnt_q <= 16'h1;
        if (tx_line) begin
          lo_len <= cnt_q;
          runs   <= runs + 16'h1;
        end else begin
          hi_len <= cnt_q;
        end
      end else begin
        cnt_q <= cnt_q + 16'h1;
      end
    end
  end
endmodule

// ### sim/sbg_checker.sv
`timescale 1ns/1ns
`include "sbg_params.svh"

// ==========================================================
// Bus and line checks for the transmitter.
module sbg_checker (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial line.
  input wire logic        tx_line
);
  logic [15:0] div_q;
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic        word_q;
  logic        lin_q;
  logic        ton_q;
  logic        wr_ok;
  logic [4:0]  lim;
  logic [31:0] max_lo;

  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign lim = (lin_q && !word_q) ? `SBG_BREAK_BITS_LIN :
               word_q ? `SBG_BREAK_BITS_9 : `SBG_BREAK_BITS_8;
  assign max_lo = {27'h0, lim} * {16'h0, div_q};

  // Shadow copies of the settings that shape the line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= `SBG_BAUD_RESET;
      word_q <= 1'b0;
      lin_q  <= 1'b0;
      ton_q  <= 1'b0;
    end else if (wr_ok) begin
      if (paddr == `SBG_ADDR_BAUD) div_q <= pwdata[15:0];
      if (paddr == `SBG_ADDR_CTRL_ONE) word_q <= pwdata[0];
      if (paddr == `SBG_ADDR_CTRL_THREE) lin_q <= pwdata[0];
      if (paddr == `SBG_ADDR_CTRL_TWO) ton_q <= pwdata[1];
    end
  end

  // Run lengths of the line in clock cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_q <= 16'h0;
      hi_q <= 16'hffff;
    end else if (tx_line) begin
      lo_q <= 16'h0;
      hi_q <= (hi_q == 16'hffff) ? hi_q : hi_q + 16'h1;
    end else begin
      hi_q <= 16'h0;
      lo_q <= lo_q + 16'h1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence apb_done;
    psel && penable && pready;
  endsequence

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  pready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  wait_state_a: assert property (psel && penable && !$past(penable) |-> !pready)
    else $error("pready in the first access cycle");
  slverr_map_a: assert property (apb_done |-> pslverr == !(paddr inside {
    `SBG_ADDR_CTRL_ONE, `SBG_ADDR_CTRL_TWO, `SBG_ADDR_CTRL_THREE,
    `SBG_ADDR_BAUD, `SBG_ADDR_DATA, `SBG_ADDR_STATUS}))
    else $error("slave error does not match the address map");
  unmapped_zero_a: assert property (apb_done and pslverr && !pwrite
    |-> prdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  break_length_a: assert property ({16'h0, lo_q} <= max_lo)
    else $error("line held low longer than a break");
  stop_bit_a: assert property ($fell(tx_line) |-> hi_q >= div_q)
    else $error("line fell without a full high bit");
  tx_off_high_a: assert property (!ton_q && !$past(ton_q, 2) |-> tx_line)
    else $error("line low while the transmitter is off");
endmodule

bind sbg_top sbg_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_line(tx_line)
);

// ### sim/tb_top.sv
`timescale 1ns/1ns
`include "sbg_params.svh"

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end

// ==========================================================
// Test bench for the break generator.
module tb_top;
  localparam int DIV = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        tx_line;
  logic [15:0] lo_len;
  logic [15:0] hi_len;
  logic [15:0] runs;
  logic [15:0] n;
  logic [1:0]  md [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  int          bl [4] = '{10, 11, 13, 11};
  int          miscompares = 0;
  int          checks = 0;
  int          k;
  time         t0;

  always #5 pclk = ~pclk;

  sbg_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_line(tx_line)
  );

  sbg_line_rx rx_u (
    .pclk(pclk), .presetn(presetn), .tx_line(tx_line),
    .lo_len(lo_len), .hi_len(hi_len), .runs(runs)
  );

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 5000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(t < 5000, 1'b1)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic brk;
    wr(`SBG_ADDR_CTRL_TWO, 32'h3);
    wr(`SBG_ADDR_CTRL_TWO, 32'h2);
  endtask

  task automatic wait_runs(input logic [15:0] m);
    int t;
    t = 0;
    while (runs < m && t < 3000) begin
      @(posedge pclk);
      t++;
    end
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SBG_ADDR_BAUD, 32'h0);
    `CHK(rd, {16'h0, `SBG_BAUD_RESET})
    apb(1'b0, `SBG_ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h4)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    wr(`SBG_ADDR_BAUD, DIV);
    wr(`SBG_ADDR_CTRL_TWO, 32'h2);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(`SBG_ADDR_CTRL_ONE, {31'h0, md[i][1]});
      wr(`SBG_ADDR_CTRL_THREE, {31'h0, md[i][0]});
      apb(1'b0, `SBG_ADDR_STATUS, 32'h0);
      `CHK(rd[3], md[i] == 2'b01)
      n = runs;
      brk();
      wait_runs(n + 16'h1);
      `CHK(lo_len, 16'(bl[i] * DIV))
      repeat (200) @(posedge pclk);
      `CHK(runs, n + 16'h1)
    end
    $display("test single breaks done");
    wr(`SBG_ADDR_CTRL_ONE, 32'h0);
    wr(`SBG_ADDR_CTRL_THREE, 32'h0);
    n = runs;
    wr(`SBG_ADDR_CTRL_TWO, 32'h3);
    wait_runs(n + 16'h3);
    `CHK(hi_len, 16'(DIV))
    wr(`SBG_ADDR_CTRL_TWO, 32'h2);
    repeat (200) @(posedge pclk);
    n = runs;
    repeat (200) @(posedge pclk);
    `CHK(runs, n)
    $display("test repeated breaks done");
    wr(`SBG_ADDR_CTRL_THREE, 32'h1);
    wr(`SBG_ADDR_CTRL_TWO, 32'h0);
    wr(`SBG_ADDR_CTRL_TWO, 32'h2);
    t0 = $time;
    n = runs;
    brk();
    k = 0;
    while (tx_line !== 1'b0 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    k = int'(($time - t0) / 10);
    `CHK(k inside {[40:48]}, 1'b1)
    wait_runs(n + 16'h1);
    `CHK(lo_len, 16'(13 * DIV))
    $display("test idle before break done");
    wr(`SBG_ADDR_CTRL_THREE, 32'h0);
    k = 0;
    do begin
      wr(`SBG_ADDR_DATA, 32'h0);
      apb(1'b0, `SBG_ADDR_STATUS, 32'h0);
      k++;
    end while (rd[1] !== 1'b1 && k < 12);
    `CHK(rd[1], 1'b1)
    wr(`SBG_ADDR_DATA, 32'h0);
    `CHK(err, 1'b0)
    k = 0;
    do begin
      repeat (20) @(posedge pclk);
      apb(1'b0, `SBG_ADDR_STATUS, 32'h0);
      k++;
    end while (rd[2:0] !== 3'b100 && k < 100);
    `CHK(rd[2:0], 3'b100)
    $display("test buffer done");
    conclude();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule
